// ===== pcsk_socket_ctrl.sv
// Behaviour
// - Power register bit 7 enables all 16-bit card output drivers; reset disabled.
// - Revision field 0010 selects original layout; otherwise extended power register layout.
// - Original layout: power bits 6, 3, 2 read zero and ignore writes.
// - Original layout: bit 5 enables automatic power switching from card detects.
// - Original layout: bit 4 enables Vcc, level from system power select bit.
// - Vpp field 00 none, 01 equals Vcc, 10 is 12 V, 11 reserved.
// - Vpp field ignored and Vpp off while socket Vcc is off.
// - Extended layout: Vcc field 00 0 V, 01 0 V, 10 5 V, 11 3.3 V.
// - Extended layout: power bits 6, 5, 2 always read zero.
// - Status bit 6 shows whether socket Vcc is switched on.
// - Control bit 7 makes the battery-detect-1 pin a ring indicate input.
// - Control bit 6 low asserts 16-bit card reset; no effect on 32-bit cards.
// - Control bit 5 gives card kind: 0 memory, 1 I/O.
// - Control bit 4 sends status-change interrupts to PCI, else to line select.
// - Select 0000 routes functional interrupts to PCI, ORed with status-change routing bit.
`timescale 1ns/1ps
`default_nettype none

module pcsk_socket_ctrl #(
   parameter logic [3:0]  REV_RESET     = 4'h4,
   parameter logic [15:0] LEGIBLE_CODES = 16'h9fbe
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   input  wire pcsk_pkg::pcsk_req_t  reg_req,
   output logic [7:0]                reg_rdata,
   input  wire logic                 system_vcc_level_select,
   input  wire logic                 card_is_32bit,
   input  wire logic                 battery_detect1_ring_pin,
   input  wire logic                 card_func_irq,
   output pcsk_pkg::pcsk_pwr_t       socket_power,
   output logic                      compat_orig_mode,
   output logic                      card_reset,
   output logic                      installed_card_kind,
   output logic                      ring_indicate_enable,
   output logic                      ring_indicate,
   output logic                      battery_detect1_level,
   output logic                      status_change_pci_routing,
   output logic                      status_change_line_select,
   output logic [15:0]               legacy_irq_lines,
   output logic                      smi_req,
   output logic                      pci_func_irq
);
   import pcsk_pkg::*;

   pcsk_state_t st_ff;
   pcsk_state_t nxt_st;
   logic        orig;
   logic [7:0]  pwr_mask;
   logic [7:0]  pwr_view;
   logic        vcc_on;
   logic [1:0]  vcc_code;
   logic [1:0]  vpp_code;

   // Layout decode for the power register
   always_comb begin
      orig     = (st_ff.idrev[REV_MSB:0] == ORIG_MODE_REV);
      pwr_mask = orig ? PWR_MASK_ORIG : PWR_MASK_EXT;
      pwr_view = st_ff.pwr & pwr_mask;
      vcc_code = st_ff.pwr[PWR_VCC_LSB +: 2];
      vpp_code = st_ff.pwr[PWR_VPP_LSB +: 2];
      if (orig) begin
         vcc_on = st_ff.pwr[PWR_VCCEN_BIT];
      end else begin
         vcc_on = (vcc_code == VCCF_5V) || (vcc_code == VCCF_3V3);
      end
   end

   // Power outputs
   always_comb begin
      socket_power.out_en  = st_ff.pwr[PWR_OE_BIT];
      socket_power.auto_sw = orig && st_ff.pwr[PWR_AUTO_BIT];
      socket_power.pwr_on  = vcc_on;
      if (!vcc_on) begin
         socket_power.vcc = VCC_OFF;
      end else if (orig) begin
         socket_power.vcc = system_vcc_level_select ? VCC_3V3 : VCC_5V;
      end else begin
         socket_power.vcc = (vcc_code == VCCF_3V3) ? VCC_3V3 : VCC_5V;
      end
      if (!vcc_on || vpp_code == VPP_RSVD) begin
         socket_power.vpp = VPP_NONE;
      end else begin
         socket_power.vpp = pcsk_vpp_t'(vpp_code);
      end
   end

   // Register writes, reads and pin synchronisers
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.ring_sync = {st_ff.ring_sync[0], battery_detect1_ring_pin};
      nxt_st.irq_sync  = {st_ff.irq_sync[0], card_func_irq};
      if (reg_req.wr) begin
         unique case (reg_req.idx)
            IDREV_IDX: nxt_st.idrev = reg_req.wdata[IDRW_MSB:0];
            PWR_IDX:   nxt_st.pwr   = reg_req.wdata & pwr_mask;
            IGC_IDX:   nxt_st.igc   = reg_req.wdata;
            default:   nxt_st.pwr   = st_ff.pwr;
         endcase
      end
      if (reg_req.rd) begin
         unique case (reg_req.idx)
            IDREV_IDX:  nxt_st.rdata = {IFTYPE_VAL, st_ff.idrev};
            IFSTAT_IDX: nxt_st.rdata = 8'(vcc_on) << IFSTAT_PWR_BIT;
            PWR_IDX:    nxt_st.rdata = pwr_view;
            IGC_IDX:    nxt_st.rdata = st_ff.igc;
            default:    nxt_st.rdata = RD_ZERO;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '{pwr: PWR_RESET, igc: IGC_RESET, idrev: {2'h0, REV_RESET},
                    rdata: RD_ZERO, ring_sync: 2'h0, irq_sync: 2'h0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Control outputs
   always_comb begin
      reg_rdata                 = st_ff.rdata;
      compat_orig_mode          = orig;
      ring_indicate_enable      = st_ff.igc[IGC_RING_BIT];
      ring_indicate             = st_ff.igc[IGC_RING_BIT] && st_ff.ring_sync[1];
      battery_detect1_level     = !st_ff.igc[IGC_RING_BIT] && st_ff.ring_sync[1];
      card_reset                = !st_ff.igc[IGC_RST_BIT] && !card_is_32bit;
      installed_card_kind       = st_ff.igc[IGC_TYPE_BIT];
      status_change_pci_routing = st_ff.igc[IGC_CSC_BIT];
      status_change_line_select = !st_ff.igc[IGC_CSC_BIT];
   end

   pcsk_irq_route #(
      .LEGIBLE_CODES(LEGIBLE_CODES)
   ) u_route (
      .functional_irq_line_select(st_ff.igc[IGC_SEL_MSB:0]),
      .card_irq                  (st_ff.irq_sync[1]),
      .status_change_pci_routing (st_ff.igc[IGC_CSC_BIT]),
      .legacy_irq_lines          (legacy_irq_lines),
      .smi_req                   (smi_req),
      .pci_func_irq              (pci_func_irq)
   );

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   oe_write_a: assert property (reg_req.wr && reg_req.idx == PWR_IDX
      |=> socket_power.out_en == $past(reg_req.wdata[PWR_OE_BIT]))
      else $error("output enable did not follow power write");
   mode_select_a: assert property (reg_req.wr && reg_req.idx == IDREV_IDX
      && reg_req.wdata[REV_MSB:0] == ORIG_MODE_REV |=> compat_orig_mode)
      else $error("original mode not selected");
   orig_reserved_a: assert property (orig && reg_req.rd && reg_req.idx == PWR_IDX
      && !(reg_req.wr && reg_req.idx == IDREV_IDX) |=> (reg_rdata & ~PWR_MASK_ORIG) == RD_ZERO)
      else $error("original layout reserved bits read nonzero");
   auto_switch_a: assert property (orig && reg_req.wr && reg_req.idx == PWR_IDX
      |=> socket_power.auto_sw == $past(reg_req.wdata[PWR_AUTO_BIT]))
      else $error("auto switch enable wrong");
   auto_ext_off_a: assert property (!orig
      |-> !socket_power.auto_sw)
      else $error("auto switch enabled in extended layout");
   orig_vcc_3v3_a: assert property (orig && st_ff.pwr[PWR_VCCEN_BIT] && system_vcc_level_select
      |-> socket_power.vcc == VCC_3V3 && socket_power.pwr_on)
      else $error("original layout 3.3 V not applied");
   orig_vcc_5v_a: assert property (orig && st_ff.pwr[PWR_VCCEN_BIT] && !system_vcc_level_select
      |-> socket_power.vcc == VCC_5V && socket_power.pwr_on)
      else $error("original layout 5 V not applied");
   orig_vcc_off_a: assert property (orig && !st_ff.pwr[PWR_VCCEN_BIT]
      |-> !socket_power.pwr_on)
      else $error("original layout Vcc on while disabled");
   vpp_follow_a: assert property (socket_power.pwr_on && vpp_code != VPP_RSVD
      |-> socket_power.vpp == vpp_code)
      else $error("Vpp request not applied");
   vpp_reserved_a: assert property (vpp_code == VPP_RSVD
      |-> socket_power.vpp == VPP_NONE)
      else $error("reserved Vpp code drove Vpp");
   vpp_gate_a: assert property (!socket_power.pwr_on
      |-> socket_power.vpp == VPP_NONE && socket_power.vcc == VCC_OFF)
      else $error("Vpp driven while Vcc off");
   ext_vcc_a: assert property (!orig && reg_req.wr && reg_req.idx == PWR_IDX
      && reg_req.wdata[PWR_VCC_LSB +: 2] == VCCF_3V3 |=> socket_power.vcc == VCC_3V3 && socket_power.pwr_on)
      else $error("extended Vcc 3.3 V request lost");
   ext_vcc_5v_a: assert property (!orig && vcc_code == VCCF_5V
      |-> socket_power.vcc == VCC_5V && socket_power.pwr_on)
      else $error("extended Vcc 5 V request lost");
   ext_vcc_zero_a: assert property (!orig && (vcc_code == VCCF_0V || vcc_code == VCCF_RSVD)
      |-> !socket_power.pwr_on)
      else $error("extended 0 V code switched Vcc on");
   ext_reserved_a: assert property (!orig && reg_req.rd && reg_req.idx == PWR_IDX
      && !(reg_req.wr && reg_req.idx == IDREV_IDX) |=> (reg_rdata & ~PWR_MASK_EXT) == RD_ZERO)
      else $error("extended layout reserved bits read nonzero");
   power_status_a: assert property (reg_req.rd && reg_req.idx == IFSTAT_IDX
      |=> reg_rdata[IFSTAT_PWR_BIT] == $past(socket_power.pwr_on))
      else $error("power status bit mismatch");
   ring_follow_a: assert property (ring_indicate_enable
      |-> ring_indicate == st_ff.ring_sync[1] && !battery_detect1_level)
      else $error("ring indicate not taken from pin");
   ring_off_a: assert property (!ring_indicate_enable
      |-> !ring_indicate && battery_detect1_level == st_ff.ring_sync[1])
      else $error("ring indicate active while disabled");
   card_reset_a: assert property (reg_req.wr && reg_req.idx == IGC_IDX
      && !reg_req.wdata[IGC_RST_BIT] ##1 !card_is_32bit |-> card_reset)
      else $error("card reset not asserted");
   reset_32bit_a: assert property (card_is_32bit
      |-> !card_reset)
      else $error("card reset driven for 32-bit card");
   card_kind_a: assert property (reg_req.wr && reg_req.idx == IGC_IDX
      |=> installed_card_kind == $past(reg_req.wdata[IGC_TYPE_BIT]))
      else $error("card kind did not follow write");
   csc_route_a: assert property (reg_req.wr && reg_req.idx == IGC_IDX
      |=> status_change_pci_routing == $past(reg_req.wdata[IGC_CSC_BIT])
      && status_change_line_select != status_change_pci_routing)
      else $error("status change routing did not follow write");
   zero_select_a: assert property (st_ff.igc[IGC_SEL_MSB:0] == SEL_NONE
      |-> legacy_irq_lines == 16'h0000 && !smi_req && pci_func_irq == st_ff.irq_sync[1])
      else $error("select 0000 routed to legacy line");
   smi_route_a: assert property (st_ff.igc[IGC_SEL_MSB:0] == SEL_SMI
      |-> legacy_irq_lines == 16'h0000 && smi_req == st_ff.irq_sync[1])
      else $error("SMI select misrouted");
   line_match_a: assert property (|legacy_irq_lines
      |-> $onehot(legacy_irq_lines) && legacy_irq_lines[st_ff.igc[IGC_SEL_MSB:0]] && st_ff.irq_sync[1])
      else $error("legacy line does not match select");
   illegible_code_a: assert property (!LEGIBLE_CODES[st_ff.igc[IGC_SEL_MSB:0]]
      |-> legacy_irq_lines == 16'h0000 && !smi_req)
      else $error("unlisted select code routed to legacy line");

endmodule : pcsk_socket_ctrl

`default_nettype wire

// ===== pcsk_pkg.sv
package pcsk_pkg;

   // Register indices inside the legacy socket register set
   localparam logic [7:0] IDREV_IDX  = 8'h00;
   localparam logic [7:0] IFSTAT_IDX = 8'h01;
   localparam logic [7:0] PWR_IDX    = 8'h02;
   localparam logic [7:0] IGC_IDX    = 8'h03;

   // Identification and revision register
   localparam logic [3:0] ORIG_MODE_REV = 4'h2;
   localparam logic [1:0] IFTYPE_VAL    = 2'h2;
   localparam int         REV_MSB       = 3;
   localparam int         IDRW_MSB      = 5;

   // Power control register fields
   localparam int         PWR_OE_BIT    = 7;
   localparam int         PWR_AUTO_BIT  = 5;
   localparam int         PWR_VCCEN_BIT = 4;
   localparam int         PWR_VCC_LSB   = 3;
   localparam int         PWR_VPP_LSB   = 0;
   localparam logic [7:0] PWR_MASK_ORIG = 8'hb3;
   localparam logic [7:0] PWR_MASK_EXT  = 8'h9b;
   localparam logic [7:0] PWR_RESET     = 8'h00;

   // Interface status register
   localparam int         IFSTAT_PWR_BIT = 6;

   // Interrupt and general control register fields
   localparam int         IGC_RING_BIT = 7;
   localparam int         IGC_RST_BIT  = 6;
   localparam int         IGC_TYPE_BIT = 5;
   localparam int         IGC_CSC_BIT  = 4;
   localparam int         IGC_SEL_MSB  = 3;
   localparam logic [7:0] IGC_RESET    = 8'h00;

   localparam logic [3:0] SEL_NONE = 4'h0;
   localparam logic [3:0] SEL_SMI  = 4'h2;
   localparam logic [7:0] RD_ZERO  = 8'h00;

   // Vcc request field codes of the extended layout
   localparam logic [1:0] VCCF_0V   = 2'h0;
   localparam logic [1:0] VCCF_RSVD = 2'h1;
   localparam logic [1:0] VCCF_5V   = 2'h2;
   localparam logic [1:0] VCCF_3V3  = 2'h3;

   typedef enum logic [1:0] {
      VPP_NONE = 2'h0,
      VPP_VCC  = 2'h1,
      VPP_12V  = 2'h2,
      VPP_RSVD = 2'h3
   } pcsk_vpp_t;

   typedef enum logic [1:0] {
      VCC_OFF = 2'h0,
      VCC_5V  = 2'h1,
      VCC_3V3 = 2'h2
   } pcsk_vcc_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] idx;
      logic [7:0] wdata;
   } pcsk_req_t;

   typedef struct packed {
      logic      out_en;
      logic      auto_sw;
      pcsk_vcc_t vcc;
      pcsk_vpp_t vpp;
      logic      pwr_on;
   } pcsk_pwr_t;

   typedef struct packed {
      logic [7:0] pwr;
      logic [7:0] igc;
      logic [5:0] idrev;
      logic [7:0] rdata;
      logic [1:0] ring_sync;
      logic [1:0] irq_sync;
   } pcsk_state_t;

endpackage : pcsk_pkg

// ===== pcsk_irq_route.sv
`timescale 1ns/1ps
`default_nettype none

module pcsk_irq_route #(
   parameter logic [15:0] LEGIBLE_CODES = 16'h9fbe
) (
   input  wire logic [3:0]  functional_irq_line_select,
   input  wire logic        card_irq,
   input  wire logic        status_change_pci_routing,
   output logic [15:0]      legacy_irq_lines,
   output logic             smi_req,
   output logic             pci_func_irq
);
   import pcsk_pkg::*;

   function automatic logic [15:0] line_onehot(input logic [3:0] sel);
      logic [15:0] v;
      v = '0;
      if (sel != SEL_NONE && sel != SEL_SMI && LEGIBLE_CODES[sel]) begin
         v[sel] = 1'b1;
      end
      return v;
   endfunction : line_onehot

   always_comb begin
      legacy_irq_lines = card_irq ? line_onehot(functional_irq_line_select) : '0;
      smi_req          = card_irq && (functional_irq_line_select == SEL_SMI);
      pci_func_irq     = card_irq && ((functional_irq_line_select == SEL_NONE)
                                      || status_change_pci_routing);
   end

endmodule : pcsk_irq_route

`default_nettype wire

// ===== pcsk_card_model.sv
`timescale 1ns/1ps
`default_nettype none

module pcsk_card_model (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic card_reset,
   input  wire logic irq_want,
   input  wire logic ring_want,
   output logic      battery_detect1_ring_pin,
   output logic      card_func_irq
);
   // A card held in reset keeps its interrupt request released
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         battery_detect1_ring_pin <= 1'b0;
         card_func_irq            <= 1'b0;
      end else begin
         battery_detect1_ring_pin <= ring_want;
         card_func_irq            <= irq_want & !card_reset;
      end
   end
endmodule : pcsk_card_model

`default_nettype wire

// ===== test_pccard_socket_power_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module test_pccard_socket_power_irq_ctrl;
   import pcsk_pkg::*;
   localparam logic [15:0] LEG = 16'h9fbe;
   logic        sys_clk = 0, rst_n = 0, sel_3v3 = 0, is32 = 0, irq_want = 0, ring_want = 0;
   pcsk_req_t   req = '0;
   pcsk_pwr_t   pwr;
   logic [7:0]  rdata;
   logic [15:0] lines;
   logic        orig, crst, kind, ring_en, ring, bvd, csc_pci, csc_line, smi, pci, pin_ring, pin_irq;
   int          num_errors = 0, samples_checked = 0, cyc = 0;
   logic [31:0] seed = 32'h12e00121;

   pcsk_socket_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
      .system_vcc_level_select(sel_3v3), .card_is_32bit(is32), .battery_detect1_ring_pin(pin_ring),
      .card_func_irq(pin_irq), .socket_power(pwr), .compat_orig_mode(orig), .card_reset(crst),
      .installed_card_kind(kind), .ring_indicate_enable(ring_en), .ring_indicate(ring),
      .battery_detect1_level(bvd), .status_change_pci_routing(csc_pci),
      .status_change_line_select(csc_line), .legacy_irq_lines(lines), .smi_req(smi), .pci_func_irq(pci));

   pcsk_card_model card (.sys_clk(sys_clk), .rst_n(rst_n), .card_reset(crst), .irq_want(irq_want),
      .ring_want(ring_want), .battery_detect1_ring_pin(pin_ring), .card_func_irq(pin_irq));

   always #5 sys_clk = ~sys_clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic pcsk_pwr_t exp_pwr(logic [7:0] v, logic om, logic s33);
      pcsk_pwr_t p;
      p.out_en  = v[7];
      p.auto_sw = om & v[5];
      p.vcc     = !v[4] ? VCC_OFF : ((om ? s33 : v[3]) ? VCC_3V3 : VCC_5V);
      p.vpp     = (!v[4] || v[1:0] == 2'h3) ? VPP_NONE : pcsk_vpp_t'(v[1:0]);
      p.pwr_on  = v[4];
      return p;
   endfunction : exp_pwr

   function automatic logic [17:0] exp_irq(logic [3:0] s, logic c, logic q);
      logic [15:0] l;
      l = (q && s != SEL_SMI && LEG[s]) ? 16'h1 << s : 16'h0;
      return {l, q && s == SEL_SMI, q && (s == SEL_NONE || c)};
   endfunction : exp_irq

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test

   task automatic chk_reg(logic [7:0] got, logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: read %h, want %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_out(logic [19:0] got, logic [19:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: outputs %h, want %h", $time, got, exp);
      end
   endtask : chk_out

   task automatic wr(logic [7:0] i, logic [7:0] d);
      @(posedge sys_clk);
      req <= '{wr: 1'b1, rd: 1'b0, idx: i, wdata: d};
      @(posedge sys_clk);
      req <= '0;
      #1;
   endtask : wr

   task automatic rd_chk(logic [7:0] i, logic [7:0] e);
      @(posedge sys_clk);
      req <= '{wr: 1'b0, rd: 1'b1, idx: i, wdata: 8'h00};
      @(posedge sys_clk);
      req <= '0;
      #1 chk_reg(rdata, e);
   endtask : rd_chk

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end

   initial begin
      logic [7:0]  w, v;
      logic [31:0] r;
      pcsk_pwr_t   e;
      repeat (19) @(posedge sys_clk);
      chk_out(pwr, '0);
      chk_out(crst, 1'b1);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      rd_chk(PWR_IDX, PWR_RESET);
      rd_chk(IGC_IDX, IGC_RESET);
      for (int m = 0; m < 2; m++) begin
         chk_out(orig, m[0]);
         for (int i = 0; i < 24; i++) begin
            r = rnd();
            if (i < 16) r[4:0] = {i[3:2], r[2], i[1:0]};
            @(posedge sys_clk);
            sel_3v3 <= r[8];
            wr(PWR_IDX, r[7:0]);
            v = r[7:0] & (m ? PWR_MASK_ORIG : PWR_MASK_EXT);
            e = exp_pwr(v, m[0], r[8]);
            chk_out(pwr, e);
            rd_chk(PWR_IDX, v);
            rd_chk(IFSTAT_IDX, {1'b0, e.pwr_on, 6'h00});
         end
         wr(PWR_IDX, 8'h00);
         wr(IDREV_IDX, {4'h0, ORIG_MODE_REV});
         rd_chk(IDREV_IDX, {2'h2, 2'h0, ORIG_MODE_REV});
      end
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         w = r[7:0];
         if (i < 16) {r[10], w[6], w[3:0]} = {2'h3, i[3:0]};
         @(posedge sys_clk);
         is32      <= r[9];
         irq_want  <= r[10];
         ring_want <= r[11];
         wr(IGC_IDX, w);
         repeat (4) @(posedge sys_clk);
         #1;
         rd_chk(IGC_IDX, w);
         chk_out({ring_en, crst, kind, csc_pci, csc_line}, {w[7], !w[6] & !r[9], w[5], w[4], !w[4]});
         chk_out({ring, bvd}, {r[11] & w[7], r[11] & !w[7]});
         chk_out({lines, smi, pci}, exp_irq(w[3:0], w[4], r[10] & (w[6] | r[9])));
      end
      wr(8'h40, 8'hff);
      rd_chk(8'h40, RD_ZERO);
      stop_test();
   end
endmodule : test_pccard_socket_power_irq_ctrl

`default_nettype wire
